/* hdl/flash_cyc_if.sv */
// Request and answer signals between the poller and the pin engine.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface flash_cyc_if;
  logic        req;    // Held until done
  logic        write;  // 1 write cycle, 0 read cycle
  logic [7:0]  wdata;  // Command byte
  logic        done;   // One-cycle end pulse
  logic [15:0] rdata;  // Word latched at end of read

  modport ctrl   (output req, write, wdata, input done, rdata);
  modport engine (input req, write, wdata, output done, rdata);
endinterface : flash_cyc_if

/* hdl/flash_cycle_engine.sv */
// Pin engine: asynchronous read or write cycles, one after the other for as long as a request is held.
// Assumes the flash pins are sampled by the board as they leave here.
`timescale 1ns/10ps
`include "flash_status_defs.svh"
module flash_cycle_engine
  import flash_status_pkg::*;
#(
  parameter int ACC_CYC = `ACCESS_CYCLES,
  parameter int WE_CYC  = `WE_CYCLES,
  parameter int REC_CYC = `RECOVER_CYCLES
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  flash_cyc_if.engine      cyc,
  input  wire logic [15:0] data_i,
  output logic             ce_n_o,
  output logic             oe_n_o,
  output logic             we_n_o,
  output logic [15:0]      data_o,
  output logic             data_oe_n_o
);

  engine_regs_t cur;   // Registered state
  engine_regs_t next_c; // Next state

  // Next state of the pin cycle
  always_comb begin
    next_c      = cur;
    next_c.done = 1'b0;
    case (cur.state)
      ENG_IDLE: begin
        // Skip the done cycle so a held request is not reused
        if (cyc.req && !cur.done) begin
          next_c.ce_n  = 1'b0;
          next_c.write = cyc.write;
          next_c.state = ENG_PULSE;
          if (cyc.write) begin
            next_c.we_n      = 1'b0;
            next_c.dout      = {8'h00, cyc.wdata};
            next_c.dout_oe_n = 1'b0;
            next_c.cnt       = 8'(WE_CYC - 1);
          end else begin
            // Falling output enable makes the device latch the word
            next_c.oe_n = 1'b0;
            next_c.cnt  = 8'(ACC_CYC - 1);
          end
        end
      end
      ENG_PULSE: begin
        if (cur.cnt == 8'h00) begin
          if (!cur.write) begin
            next_c.rdata = data_i;
          end
          // Raise enables so the next read relatches
          next_c.oe_n  = 1'b1;
          next_c.we_n  = 1'b1;
          next_c.ce_n  = 1'b1;
          next_c.cnt   = 8'(REC_CYC - 1);
          next_c.state = ENG_REC;
        end else begin
          next_c.cnt = cur.cnt - 8'h01;
        end
      end
      ENG_REC: begin
        if (cur.cnt == 8'h00) begin
          next_c.dout_oe_n = 1'b1;
          next_c.done      = 1'b1;
          next_c.state     = ENG_IDLE;
        end else begin
          next_c.cnt = cur.cnt - 8'h01;
        end
      end
      default: begin
        next_c.state = ENG_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '{state: ENG_IDLE, cnt: 8'h00, write: 1'b0, ce_n: 1'b1,
               oe_n: 1'b1, we_n: 1'b1, dout: 16'h0000, dout_oe_n: 1'b1,
               rdata: 16'h0000, done: 1'b0};
    end else begin
      cur <= next_c;
    end
  end

  assign ce_n_o      = cur.ce_n;
  assign oe_n_o      = cur.oe_n;
  assign we_n_o      = cur.we_n;
  assign data_o      = cur.dout;
  assign data_oe_n_o = cur.dout_oe_n;
  assign cyc.done    = cur.done;
  assign cyc.rdata   = cur.rdata;

  // Output enable stays high for the whole recovery before a new read
  a_oe_recovery: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(cur.oe_n) |-> cur.oe_n [*4])
    else $error("output enable not held high between reads");

  // Never drive the data lines while the device drives them
  a_no_contention: assert property (@(posedge clk_i) disable iff (rst_i)
    !cur.oe_n |-> (cur.dout_oe_n && cur.we_n))
    else $error("data driven during a read cycle");

  // Done is a single pulse
  a_done_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    cur.done |=> !cur.done)
    else $error("done held longer than one cycle");

endmodule : flash_cycle_engine

/* hdl/flash_status_defs.svh */
// Offsets, field positions, reset values and timing counts of the
// status poller. Assumes a 125 MHz system clock.
`ifndef FLASH_STATUS_DEFS_SVH
`define FLASH_STATUS_DEFS_SVH

// Register byte offsets on the bus
`define REG_CTRL      8'h00
`define REG_CMD       8'h04
`define REG_STATE     8'h08
`define REG_IRQ_STAT  8'h0c
`define REG_IRQ_MASK  8'h10

// Control register fields
`define CTRL_GO_BIT       0
`define CTRL_USE_PIN_BIT  1
`define CTRL_SEND_BIT     2

// Reset value of the command register
`define CMD_RESET  8'hff
// Command code that selects status reads
`define READ_STATUS_CMD  8'h70

// Status word fields
`define SR_READY_BIT       7
`define SR_ERASE_SUSP_BIT  6
`define SR_ERASE_ERR_BIT   5
`define SR_PROG_ERR_BIT    4
`define SR_LOW_VOLT_BIT    3
`define SR_PROG_SUSP_BIT   2
`define SR_LOCK_ABORT_BIT  1
`define SR_RESERVED_BIT    0

// Interrupt status and mask fields
`define IRQ_DONE_BIT  0
`define IRQ_ERR_BIT   1
`define IRQ_SUSP_BIT  2
`define IRQ_WIDTH     3

// Pin timing, in ns, and derived clock counts (rounded up)
`define CLK_PERIOD_PS   8000
`define T_ACCESS_NS     120
`define T_WE_PULSE_NS   70
`define T_RECOVER_NS    30
`define CYCLES_MIN(ns)  ((((ns) * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ACCESS_CYCLES   `CYCLES_MIN(`T_ACCESS_NS)
`define WE_CYCLES       `CYCLES_MIN(`T_WE_PULSE_NS)
`define RECOVER_CYCLES  `CYCLES_MIN(`T_RECOVER_NS)

`endif

/* hdl/flash_status_pkg.sv */
// Types shared by the status poller and its pin cycle engine.
// Assumes nothing of its surroundings.
package flash_status_pkg;

  // Pin cycle engine states
  typedef enum logic [2:0] {
    ENG_IDLE  = 3'b001,
    ENG_PULSE = 3'b010,
    ENG_REC   = 3'b100
  } engine_state_t;

  // Poller states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_SEND  = 6'b000010,
    ST_CMD   = 6'b000100,
    ST_WAIT  = 6'b001000,
    ST_POLL  = 6'b010000,
    ST_FINAL = 6'b100000
  } poll_state_t;

  // Whole state of the pin cycle engine
  typedef struct packed {
    engine_state_t state;
    logic [7:0]    cnt;
    logic          write;
    logic          ce_n;
    logic          oe_n;
    logic          we_n;
    logic [15:0]   dout;
    logic          dout_oe_n;
    logic [15:0]   rdata;
    logic          done;
  } engine_regs_t;

  // Whole state of the poller
  typedef struct packed {
    poll_state_t state;
    logic        ack;
    logic [31:0] rdata;
    logic        use_pin;
    logic [7:0]  cmd;
    logic        mode;
    logic        busy;
    logic [7:0]  status;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic        req;
    logic        wr;
    logic [7:0]  wdata;
  } poll_regs_t;

endpackage : flash_status_pkg

/* hdl/flash_status_poller.sv */
// Host side status poller for a parallel flash, with a Wishbone
// slave for software. Assumes the board ties the address pins and
// that pin inputs are synchronous to CLOCK_I.
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "flash_status_defs.svh"

// Status word clean-up and classification
module status_decoder (
  input  wire logic [7:0] raw_i,
  output logic [7:0]      clean_o,
  output logic            fail_o,
  output logic            susp_o
);
  // Reserved bit masked out of every evaluation
  always_comb begin
    clean_o                   = raw_i;
    clean_o[`SR_RESERVED_BIT] = 1'b0;
    // Erase, program, low voltage and lock abort count as failure
    fail_o = clean_o[`SR_ERASE_ERR_BIT] | clean_o[`SR_PROG_ERR_BIT]
           | clean_o[`SR_LOW_VOLT_BIT]
           | clean_o[`SR_LOCK_ABORT_BIT];
    // Either suspend flag marks the finished poll as suspended
    susp_o = clean_o[`SR_ERASE_SUSP_BIT] | clean_o[`SR_PROG_SUSP_BIT];
  end
endmodule : status_decoder

// Functional notes
// - Status mode has no page reads.
// - Toggle output enable between status reads.
// - Ready bit or completion pin shows done.
// - Lock state read via identifier mode.
// - Mask reserved bit zero when polling.
module flash_status_poller
  import flash_status_pkg::*;
#(
  parameter logic [7:0] STATUS_CMD = `READ_STATUS_CMD
)(
  input  wire logic        CLOCK_I,
  input  wire logic        RESET_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             IRQ_O,
  output logic             FLASH_CE_N_O,
  output logic             FLASH_OE_N_O,
  output logic             FLASH_WE_N_O,
  input  wire logic [15:0] FLASH_DATA_I,
  output logic [15:0]      FLASH_DATA_O,
  output logic             FLASH_DATA_OE_N_O,
  input  wire logic        FLASH_COMPLETION_I
);

  poll_regs_t  cur;      // Registered state
  poll_regs_t  next_p;   // Next state
  flash_cyc_if cyc ();   // Link to pin engine
  logic [7:0]  clean;    // Word with reserved bit cleared
  logic        fail;     // Any error flag set
  logic        susp;     // Any suspend flag set
  logic        access;   // Bus access in its ack cycle
  logic        wr_ok;    // Write takes effect this edge
  logic [2:0]  irq_set;  // Events this cycle
  logic [2:0]  irq_clr;  // Write one to clear
  logic        go;       // Start a poll
  logic        send;     // Send the command register

  // Pin cycle engine
  flash_cycle_engine u_engine (
    .clk_i       (CLOCK_I),
    .rst_i       (RESET_I),
    .cyc         (cyc.engine),
    .data_i      (FLASH_DATA_I),
    .ce_n_o      (FLASH_CE_N_O),
    .oe_n_o      (FLASH_OE_N_O),
    .we_n_o      (FLASH_WE_N_O),
    .data_o      (FLASH_DATA_O),
    .data_oe_n_o (FLASH_DATA_OE_N_O)
  );

  // Decoder looks only at the low byte; upper lines may float
  status_decoder u_decoder (
    .raw_i   (cyc.rdata[7:0]),
    .clean_o (clean),
    .fail_o  (fail),
    .susp_o  (susp)
  );

  // Bus strobes
  assign access  = WB_CYC_I & WB_STB_I & cur.ack;
  assign wr_ok   = access & WB_WE_I & WB_SEL_I[0];
  assign go      = wr_ok && WB_ADR_I == `REG_CTRL && WB_DAT_I[`CTRL_GO_BIT];
  assign send    = wr_ok && WB_ADR_I == `REG_CTRL && WB_DAT_I[`CTRL_SEND_BIT];
  assign irq_clr = (wr_ok && WB_ADR_I == `REG_IRQ_STAT) ? WB_DAT_I[2:0] : 3'h0;

  // Next state: bus slave, poll sequence, interrupts
  always_comb begin
    next_p  = cur;
    irq_set = 3'h0;
    // Ack one cycle after the strobe, dropped after one cycle
    next_p.ack = WB_CYC_I & WB_STB_I & ~cur.ack;
    // Read data captured with the ack
    if (WB_ADR_I == `REG_CTRL) begin
      next_p.rdata = {30'h0, cur.use_pin, 1'b0};
    end else if (WB_ADR_I == `REG_CMD) begin
      next_p.rdata = {24'h0, cur.cmd};
    end else if (WB_ADR_I == `REG_STATE) begin
      next_p.rdata = {16'h0, cur.status, 6'h0, cur.mode, cur.busy};
    end else if (WB_ADR_I == `REG_IRQ_STAT) begin
      next_p.rdata = {29'h0, cur.irq_stat};
    end else if (WB_ADR_I == `REG_IRQ_MASK) begin
      next_p.rdata = {29'h0, cur.irq_mask};
    end else begin
      // Unmapped offsets read zero
      next_p.rdata = 32'h0;
    end
    // Register writes
    if (wr_ok && WB_ADR_I == `REG_CTRL) begin
      next_p.use_pin = WB_DAT_I[`CTRL_USE_PIN_BIT];
    end else if (wr_ok && WB_ADR_I == `REG_CMD) begin
      next_p.cmd = WB_DAT_I[7:0];
    end else if (wr_ok && WB_ADR_I == `REG_IRQ_MASK) begin
      next_p.irq_mask = WB_DAT_I[2:0];
    end
    // Poll sequence
    case (cur.state)
      ST_IDLE: begin
        if (send) begin
          // Any command leaves status mode unless it is the status one
          next_p.req   = 1'b1;
          next_p.wr    = 1'b1;
          next_p.wdata = cur.cmd;
          next_p.busy  = 1'b1;
          next_p.state = ST_SEND;
        end else if (go) begin
          next_p.busy = 1'b1;
          if (!cur.mode) begin
            // Status command issued regardless of program voltage
            next_p.req   = 1'b1;
            next_p.wr    = 1'b1;
            next_p.wdata = STATUS_CMD;
            next_p.state = ST_CMD;
          end else begin
            // Already in status mode: no command needed
            next_p.state = ST_WAIT;
          end
        end
      end
      ST_SEND: begin
        if (cyc.done) begin
          next_p.req   = 1'b0;
          next_p.busy  = 1'b0;
          next_p.mode  = (cur.cmd == STATUS_CMD);
          next_p.state = ST_IDLE;
        end
      end
      ST_CMD: begin
        if (cyc.done) begin
          next_p.req   = 1'b0;
          next_p.mode  = 1'b1;
          next_p.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Optional wait on the completion pin before reading
        if (!cur.use_pin || FLASH_COMPLETION_I) begin
          // Single word reads only, never page bursts
          next_p.req   = 1'b1;
          next_p.wr    = 1'b0;
          next_p.state = ST_POLL;
        end
      end
      ST_POLL: begin
        // Only the ready bit is trusted while the engine is busy
        if (cyc.done && cyc.rdata[`SR_READY_BIT]) begin
          // One more read so that every bit is valid
          next_p.state = ST_FINAL;
        end
      end
      ST_FINAL: begin
        if (cyc.done) begin
          next_p.req    = 1'b0;
          next_p.busy   = 1'b0;
          // Lock abort kept as an event flag, not a lock state
          next_p.status = clean;
          irq_set[`IRQ_DONE_BIT] = 1'b1;
          irq_set[`IRQ_ERR_BIT]  = fail;
          irq_set[`IRQ_SUSP_BIT] = susp;
          next_p.state  = ST_IDLE;
        end
      end
      default: begin
        next_p.state = ST_IDLE;
      end
    endcase
    // Sticky flags: a set in the clearing cycle wins
    next_p.irq_stat = (cur.irq_stat & ~irq_clr) | irq_set;
  end

  // State register
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cur <= '{state: ST_IDLE, ack: 1'b0, rdata: 32'h0, use_pin: 1'b0,
               cmd: `CMD_RESET, mode: 1'b0, busy: 1'b0, status: 8'h00,
               irq_stat: 3'h0, irq_mask: 3'h0, req: 1'b0, wr: 1'b0,
               wdata: 8'h00};
    end else begin
      cur <= next_p;
    end
  end

  // Engine request and bus outputs
  assign cyc.req   = cur.req;
  assign cyc.write = cur.wr;
  assign cyc.wdata = cur.wdata;
  assign WB_DAT_O  = cur.rdata;
  assign WB_ACK_O  = cur.ack;
  assign IRQ_O     = |(cur.irq_stat & cur.irq_mask);

  // Interrupt only rises after a finished poll or a new mask
  a_irq_level: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    $rose(IRQ_O) |-> ($past(cur.state) == ST_FINAL || $past(cur.irq_mask) != cur.irq_mask))
    else $error("interrupt rose with no cause");

  // Ack lasts one cycle
  a_ack_single: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held two cycles");

  // Reserved bit never reported
  a_reserved_masked: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    !cur.status[`SR_RESERVED_BIT])
    else $error("reserved status bit reported");

  // Status command completion puts the host in status mode
  a_mode_entry: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (cur.state == ST_CMD && cyc.done) |=> (cur.mode && cur.state == ST_WAIT))
    else $error("status mode not entered");

  // A busy answer leads to another read, never to a result
  a_busy_repoll: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (cur.state == ST_POLL && cyc.done && !cyc.rdata[`SR_READY_BIT])
    |=> (cur.state == ST_POLL && cur.busy))
    else $error("busy answer ended the poll");

  // Ready answer is followed by a final full read
  a_final_read: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (cur.state == ST_POLL && cyc.done && cyc.rdata[`SR_READY_BIT])
    |=> cur.state == ST_FINAL ##1 !FLASH_OE_N_O)
    else $error("no final read after ready");

  // No read starts while waiting on the completion pin
  a_pin_wait: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (cur.state == ST_WAIT && cur.use_pin && !FLASH_COMPLETION_I) |=> !cur.req)
    else $error("read started before completion pin");

  // Any of the four failure bits raises the error interrupt
  a_error_flag: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (cur.state == ST_FINAL && cyc.done && fail) |=> cur.irq_stat[`IRQ_ERR_BIT])
    else $error("error flag not raised");

  // Any other command sent leaves status mode
  a_send_exit: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (cur.state == ST_SEND && cyc.done && cur.cmd != STATUS_CMD) |=> !cur.mode)
    else $error("status mode kept after another command");

  // Stored word is the final read with only the reserved bit cleared
  a_word_stored: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (cur.state == ST_FINAL && cyc.done) |=> cur.status[7:1] == $past(cyc.rdata[7:1]))
    else $error("stored status word differs from final read");

  // An idle poller keeps the pin engine quiet
  a_idle_quiet: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    cur.state == ST_IDLE |-> (!cur.req && !cur.busy))
    else $error("engine requested while idle");

  // Scenarios of interest
  c_poll_done: cover property (@(posedge CLOCK_I) disable iff (RESET_I)
    cur.state == ST_FINAL && cyc.done);
  c_busy_loop: cover property (@(posedge CLOCK_I) disable iff (RESET_I)
    cur.state == ST_POLL && cyc.done && !cyc.rdata[`SR_READY_BIT]);
  c_suspend: cover property (@(posedge CLOCK_I) disable iff (RESET_I)
    cur.state == ST_FINAL && cyc.done && susp);
  c_send_other: cover property (@(posedge CLOCK_I) disable iff (RESET_I)
    cur.state == ST_SEND && cyc.done && cur.cmd != STATUS_CMD);
  c_pin_wait: cover property (@(posedge CLOCK_I) disable iff (RESET_I)
    cur.state == ST_WAIT && cur.use_pin && !FLASH_COMPLETION_I);

endmodule : flash_status_poller

/* testbench/flash_device_model.sv */
// Behavioural flash device that answers command writes and status reads.
// Assumes the bench resolves the shared data bus from the host data enable.
`timescale 1ns/10ps
module flash_device_model (
  input  wire logic        ce_n_i,       // Chip select
  input  wire logic        oe_n_i,       // Output enable
  input  wire logic        we_n_i,       // Write enable
  input  wire logic        host_oe_n_i,  // Host drives bus when low
  input  wire logic [15:0] bus_i,        // Resolved data bus
  input  wire logic        busy_i,       // Write engine running
  input  wire logic [7:0]  word_i,       // Status word once ready
  output logic [15:0]      data_o,       // Device side of the bus
  output logic             ready_o,      // Completion pin
  output int               cmds_o        // Status commands seen
);
  logic        mode;   // Status read mode
  logic [15:0] shown;  // Output latch
  wire         rd_n;   // Read enabled when low
  wire         wr_n;   // Write strobe, active low

  assign rd_n = ce_n_i | oe_n_i;
  assign wr_n = ce_n_i | we_n_i;

  initial begin
    mode   = 1'b0;
    shown  = 16'h0000;
    cmds_o = 0;
  end

  // Command taken at the end of the write strobe
  always @(posedge wr_n) begin
    if (host_oe_n_i === 1'b0) begin
      mode = (bus_i[7:0] == 8'h70);
      if (mode)
        cmds_o = cmds_o + 1;
    end
  end

  // Latch only on the enabling edge, one word, no page buffer
  always @(negedge rd_n) begin
    if (!mode)
      shown = 16'ha55a;  // Array data stand-in
    else if (busy_i)
      shown = {~shown[15:8], 1'b0, ~shown[6:0]};
    else
      shown = {8'h00, word_i};
  end

  // Released bus never shows the stale word
  assign data_o  = rd_n ? ~shown : shown;
  assign ready_o = ~busy_i;
endmodule : flash_device_model

/* testbench/flash_status_readout_bench.sv */
// Self-checking bench of the flash status poller over Wishbone.
// Assumes the device model file and a 125 MHz clock.
`timescale 1ns/10ps
`include "flash_status_defs.svh"
module flash_status_readout_bench;
  typedef struct {
    logic        chk;
    logic [31:0] v;
  } note_t;

  logic        clk = 1'b0;        // System clock
  logic        rst = 1'b1;        // Reset, active high
  logic        cyc = 1'b0;        // Bus cycle
  logic        stb = 1'b0;        // Bus strobe
  logic        we = 1'b0;         // Bus direction
  logic [7:0]  adr = 8'h00;       // Bus address
  logic [31:0] wdat = 32'h0;      // Bus write data
  logic [3:0]  sel = 4'h0;        // Bus byte selects
  logic [3:0]  sel_req = 4'hf;    // Selects for the next request
  logic        dev_busy = 1'b0;   // Device engine busy
  logic [7:0]  dev_word = 8'h80;  // Device final word
  logic [31:0] seed = 32'd58;     // Xorshift state
  wire  [31:0] rdat;              // Bus read data
  wire         ack;               // Bus acknowledge
  wire         irq;               // Interrupt
  wire         ce_n;              // Flash pins
  wire         oe_n;
  wire         we_n;
  wire         doe_n;
  wire         ready;             // Completion pin
  wire  [15:0] dout;              // Host data
  wire  [15:0] ddev;              // Device data
  wire  [15:0] bus;               // Resolved bus
  int          cmds;              // Status commands seen
  int          error_cnt = 0;     // Mismatches
  int          check_count = 0;   // Comparisons
  int          cycles = 0;        // Timeout counter
  note_t       notes[$];          // Expected read results
  note_t       cur;               // Note being compared
  logic [7:0]  words [10] = '{8'h80, 8'hc0, 8'ha0, 8'h90, 8'h88,
                              8'h84, 8'h82, 8'h81, 8'hb0, 8'hff};

  always #4 clk = ~clk;

  // Host drives when its enable is low, else the device
  assign bus = !doe_n ? dout : ddev;

  flash_status_poller flash_status_poller_inst (
    .CLOCK_I(clk), .RESET_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ_O(irq), .FLASH_CE_N_O(ce_n),
    .FLASH_OE_N_O(oe_n), .FLASH_WE_N_O(we_n), .FLASH_DATA_I(bus),
    .FLASH_DATA_O(dout), .FLASH_DATA_OE_N_O(doe_n), .FLASH_COMPLETION_I(ready)
  );

  flash_device_model flash_device_model_inst (
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .host_oe_n_i(doe_n),
    .bus_i(bus), .busy_i(dev_busy), .word_i(dev_word), .data_o(ddev),
    .ready_o(ready), .cmds_o(cmds)
  );

  // Xorshift source for stimulus
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // One comparison, counted
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Counts, verdict, end of run
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Classic single Wishbone cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= sel_req;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    sel <= 4'h0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  // Checked read: expectation queued first
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    notes.push_back('{1'b1, exp});
    wb(1'b0, a, 32'h0, q);
  endtask : rd

  // Unchecked read for waiting
  task automatic peek(input logic [7:0] a, output logic [31:0] q);
    notes.push_back('{1'b0, 32'h0});
    wb(1'b0, a, 32'h0, q);
  endtask : peek

  // Wait until the poller is idle
  task automatic wait_idle();
    logic [31:0] q;
    int          n;
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 100) begin
      peek(`REG_STATE, q);
      n++;
    end
  endtask : wait_idle

  // One poll with a slow engine, then results and interrupt
  task automatic poll(input logic [7:0] w, input logic pin, input logic [2:0] mask);
    logic [2:0] ie;
    ie = {w[6] | w[2], w[5] | w[4] | w[3] | w[1], 1'b1};
    dev_word <= w;
    dev_busy <= 1'b1;
    wr(`REG_IRQ_MASK, {29'h0, mask});
    wr(`REG_CTRL, {30'h0, pin, 1'b1});
    repeat (60 + rnd() % 100) @(posedge clk);
    dev_busy <= 1'b0;
    wait_idle();
    rd(`REG_STATE, {16'h0, w & 8'hfe, 8'h02});
    rd(`REG_IRQ_STAT, {29'h0, ie});
    rd(`REG_CTRL, {30'h0, pin, 1'b0});
    check({31'h0, irq}, {31'h0, |(ie & mask)});
    wr(`REG_IRQ_STAT, 32'h7);
    rd(`REG_IRQ_STAT, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask : poll

  // Oldest note compared whenever read data appears
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && notes.size() > 0) begin
      cur = notes.pop_front();
      if (cur.chk)
        check(rdat, cur.v);
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    logic [7:0] c;
    logic [7:0] w;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({28'h0, ce_n, oe_n, we_n, doe_n}, 32'hf);
    // Reset values, unmapped place, command register
    rd(`REG_CMD, 32'hff);
    rd(`REG_STATE, 32'h0);
    rd(`REG_IRQ_STAT, 32'h0);
    rd(`REG_IRQ_MASK, 32'h0);
    rd(`REG_CTRL, 32'h0);
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 32'h0);
    c = 8'(rnd());
    wr(`REG_CMD, {24'h0, c});
    rd(`REG_CMD, {24'h0, c});
    // Write with byte lane 0 off is dropped
    sel_req = 4'he;
    wr(`REG_CMD, 32'h0);
    sel_req = 4'hf;
    rd(`REG_CMD, {24'h0, c});
    $display("Test registers done");
    // Every status bit, then random words; pin alternating, masks random
    for (int i = 0; i < 14; i++) begin
      w = (i < 10) ? words[i] : (8'(rnd()) | 8'h80);
      c = 8'(rnd());
      poll(w, i[0], c[2:0]);
      if (i == 0)
        check(cmds, 1);
    end
    check(cmds, 1);
    $display("Test polls done");
    // Another command leaves status mode; sending the status one restores it
    wr(`REG_CMD, 32'hff);
    wr(`REG_CTRL, 32'h4);
    wait_idle();
    rd(`REG_STATE, {16'h0, w & 8'hfe, 8'h00});
    wr(`REG_CMD, {24'h0, `READ_STATUS_CMD});
    wr(`REG_CTRL, 32'h4);
    wait_idle();
    rd(`REG_STATE, {16'h0, w & 8'hfe, 8'h02});
    poll(8'h80, 1'b0, 3'h1);
    check(cmds, 2);
    $display("Test mode change done");
    give_verdict();
  end
endmodule : flash_status_readout_bench
